// File: hw/rsc_defs.svh
// constants of the reset source controller
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define RSC_ADDR_CAUSE      8'hEF
`define RSC_ADDR_SUPPLY     8'hFF

`define RSC_BIT_PIN         0
`define RSC_BIT_POR         1
`define RSC_BIT_CLK_LOSS    2
`define RSC_BIT_WDOG        3
`define RSC_BIT_SW          4
`define RSC_BIT_CMP         5
`define RSC_BIT_FLASH       6
`define RSC_BIT_USB         7
`define RSC_BIT_MON_ON      7
`define RSC_BIT_LEVEL_OK    6

`define RSC_LIMIT_32K       16'h7FFF
`define RSC_LIMIT_64K       16'hFBFF

`define RSC_CLK_PERIOD_NS   100
`define RSC_RESET_DELAY_NS  5000
`define RSC_MON_TURNON_NS   100000
`define RSC_CLK_LOSS_NS     100000
`define RSC_PIN_LOW_MIN_NS  15000
`define RSC_RESET_DELAY_CYC ((`RSC_RESET_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_MON_TURNON_CYC  ((`RSC_MON_TURNON_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_WDOG_PRESCALE   12

`endif

// File: hw/rsc_pkg.sv
// types of the reset source controller
package rsc_pkg;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_HOLD  = 3'b010,
    ST_DELAY = 3'b100
  } rsc_state_t;

  // one bit per reset cause, in register bit order
  typedef struct packed {
    logic usb;
    logic flash;
    logic cmp;
    logic sw;
    logic wdog;
    logic clk_loss;
    logic por;
    logic pin;
  } rsc_cause_t;

  // one flash access from the core, same clock
  typedef struct packed {
    logic        data_write;
    logic        code_read;
    logic        fetch;
    logic        program_store_write_enable;
    logic        sec_block;
    logic [15:0] addr;
  } rsc_flash_req_t;

  // special function register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsc_sfr_req_t;

endpackage : rsc_pkg

// File: hw/rsc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= INIT;
      q    <= INIT;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : rsc_sync
`default_nettype wire

// File: hw/rsc_watchdog.sv
// watchdog counting system clock divided by twelve
`timescale 1ns/1ps
`include "rsc_defs.svh"
`default_nettype none
module rsc_watchdog #(
  parameter int TICKS = 256
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // software control
  input  wire logic kick,
  input  wire logic disable_req,
  // expiry
  output logic      timeout
);
  localparam int PW = $clog2(`RSC_WDOG_PRESCALE);
  localparam int TW = $clog2(TICKS + 1);
  logic [PW-1:0] pre;
  logic [TW-1:0] cnt;
  logic          enabled;
  logic          tick;

  assign tick = (pre == PW'(`RSC_WDOG_PRESCALE - 1));

  always_ff @(posedge clk)
  begin
    if (rst)
      pre <= '0;
    else
      pre <= tick ? '0 : pre + 1'b1;
  end

  // enabled after every reset
  always_ff @(posedge clk)
  begin
    if (rst)
      enabled <= 1'b1; // RL12
    else if (disable_req)
      enabled <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst || kick || !enabled)
    begin
      cnt     <= '0;
      timeout <= 1'b0;
    end
    else if (tick)
    begin
      timeout <= (cnt == TW'(TICKS - 1)); // RL12
      cnt     <= cnt + 1'b1;
    end
    else
      timeout <= 1'b0;
  end
endmodule : rsc_watchdog
`default_nettype wire

// File: hw/rsc_top.sv
// reset source controller: collects reset sources, records the cause
// Contract
// RL1: supply monitor on bit; monitor resets only when also selected as source.
// RL2: selecting monitor as source before it has stabilised causes a reset.
// RL3: every power-on reset turns the supply monitor on.
// RL4: supply level bit is read-only live monitor output, 1 above threshold.
// RL5: low six bits of supply control register are reserved, writes ignored.
// RL6: low reset pin resets device; pin flag reads 1 only after pin reset.
// RL7: enabled clock loss detector times out and resets the device.
// RL8: clock loss bit writes enable, reads 1 only after clock loss reset.
// RL9: internal resets other than power and supply leave reset pin undriven.
// RL10: comparator bit enables comparator reset when plus input below minus input.
// RL11: software should let the comparator settle before enabling it as source.
// RL12: watchdog enabled after any reset, clock divided by twelve, resets on expiry.
// RL13: watchdog flag is read-only, reads 1 only after watchdog reset.
// RL14: program store write above user code limit gives flash error reset.
// RL15: code space read above user code limit gives flash error reset.
// RL16: fetch above user code limit gives flash error reset.
// RL17: flash write with monitor off, or security block, gives flash error reset.
// RL18: flash fault flag reads 1 only after flash error reset.
// RL19: writing 1 to software bit forces a reset; flag reads 1 afterwards.
// RL20: bus reset bit enables resets from bus reset signaling or bus voltage.
// RL21: power-on flag set by power or supply reset; write selects monitor source.
// RL22: read-modify-write reads the stored enables, not the cause flags.
// RL23: at least 5 us pass after reset release before code runs.
// RL24: external circuitry holds the pin low at least 15 us.
// RL25: cause flags captured at reset entry, held until next reset.
`timescale 1ns/1ps
`include "rsc_defs.svh"
`default_nettype none
module rsc_top #(
  parameter int WDOG_TICKS = 256,
  parameter int MON_TURNON = `RSC_MON_TURNON_CYC
) (
  // clock and power-on reset
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST,
  // reset pin, open drain
  input  wire logic                    RST_PIN_IN_N,
  output logic                         RST_PIN_OUT,
  output logic                         RST_PIN_OE_N,
  // analog sources, asynchronous
  input  wire logic                    SUPPLY_ABOVE,
  input  wire logic                    CMP_BELOW,
  input  wire logic                    CLK_LOSS_EXPIRED,
  input  wire logic                    VBUS_LEVEL,
  // usb controller, same clock
  input  wire logic                    USB_ON,
  input  wire logic                    USB_BUS_RESET,
  input  wire logic                    VBUS_POLARITY,
  // watchdog service, same clock
  input  wire logic                    WDOG_KICK,
  input  wire logic                    WDOG_DISABLE,
  // flash accesses and size
  input  wire rsc_pkg::rsc_flash_req_t FLASH_REQ,
  input  wire logic                    FLASH_64K,
  // special function registers
  input  wire rsc_pkg::rsc_sfr_req_t   SFR_REQ,
  output logic [7:0]                   SFR_RDATA,
  // system side
  output logic                         SYS_RESET,
  output logic                         SUPPLY_MON_ON,
  output logic                         CLK_LOSS_EN
);
  localparam int DW = $clog2(`RSC_RESET_DELAY_CYC + 1);
  localparam int MW = $clog2(MON_TURNON + 1);

  rsc_pkg::rsc_state_t state;
  rsc_pkg::rsc_cause_t cause;
  rsc_pkg::rsc_cause_t next_cause;
  logic [DW-1:0]       delay_cnt;
  logic [MW-1:0]       mon_cnt;
  logic                usb_en;
  logic                cmp_en;
  logic                vdm_sel;
  logic                pin_low;
  logic                level_ok;
  logic                cmp_low;
  logic                clk_loss;
  logic                vbus;
  logic                wdog_to;
  logic                wr_cause;
  logic                wr_supply;
  logic                mon_stable;
  logic                vdm_fault;
  logic                vdm_early;
  logic                flash_err;
  logic                usb_trip;
  logic                hold_src;
  logic                any_trip;
  logic [1:0]          drive_hist;
  logic                pin_ext;

  function automatic logic over_limit(input logic [15:0] a, input logic big);
    over_limit = big ? (a > `RSC_LIMIT_64K) : (a > `RSC_LIMIT_32K);
  endfunction : over_limit

  // pin idles high, so the synced low flag starts clear
  rsc_sync #(.W(1), .INIT(1'b0)) u_pin_sync (
    .clk (CLK_SYS),
    .rst (RST),
    .d   (~RST_PIN_IN_N),
    .q   (pin_low)
  );

  // supply starts as good, the other sources idle low
  rsc_sync #(.W(4), .INIT(4'h8)) u_analog_sync (
    .clk (CLK_SYS),
    .rst (RST),
    .d   ({SUPPLY_ABOVE, CMP_BELOW, CLK_LOSS_EXPIRED, VBUS_LEVEL}),
    .q   ({level_ok, cmp_low, clk_loss, vbus})
  );

  rsc_watchdog #(.TICKS(WDOG_TICKS)) u_wdog (
    .clk         (CLK_SYS),
    .rst         (RST | SYS_RESET),
    .kick        (WDOG_KICK),
    .disable_req (WDOG_DISABLE),
    .timeout     (wdog_to)
  );

  assign wr_cause  = SFR_REQ.wr && (SFR_REQ.addr == `RSC_ADDR_CAUSE) && (state == rsc_pkg::ST_RUN);
  assign wr_supply = SFR_REQ.wr && (SFR_REQ.addr == `RSC_ADDR_SUPPLY) && (state == rsc_pkg::ST_RUN);
  assign mon_stable = SUPPLY_MON_ON && (mon_cnt == MW'(MON_TURNON));

  // monitor resets only when both on and selected
  assign vdm_fault = SUPPLY_MON_ON && vdm_sel && !level_ok; // RL1
  assign vdm_early = wr_cause && SFR_REQ.wdata[`RSC_BIT_POR] && !mon_stable; // RL2
  assign hold_src  = pin_ext || vdm_fault; // RL6

  always_comb
  begin
    flash_err = 1'b0;
    if (FLASH_REQ.data_write && FLASH_REQ.program_store_write_enable && over_limit(FLASH_REQ.addr, FLASH_64K))
      flash_err = 1'b1; // RL14
    if (FLASH_REQ.code_read && over_limit(FLASH_REQ.addr, FLASH_64K))
      flash_err = 1'b1; // RL15
    if (FLASH_REQ.fetch && over_limit(FLASH_REQ.addr, FLASH_64K))
      flash_err = 1'b1; // RL16
    if ((FLASH_REQ.data_write && FLASH_REQ.program_store_write_enable && !SUPPLY_MON_ON) || FLASH_REQ.sec_block)
      flash_err = 1'b1; // RL17
  end

  assign usb_trip = usb_en && ((USB_ON && USB_BUS_RESET) || (vbus == VBUS_POLARITY)); // RL20

  // one cause wins; pin and supply first since they hold the device
  always_comb
  begin
    next_cause = '0;
    if (pin_ext)
      next_cause.pin = 1'b1; // RL6
    else if (vdm_fault || vdm_early)
      next_cause.por = 1'b1; // RL21
    else if (CLK_LOSS_EN && clk_loss)
      next_cause.clk_loss = 1'b1; // RL7
    else if (cmp_en && cmp_low)
      next_cause.cmp = 1'b1; // RL10
    else if (wdog_to)
      next_cause.wdog = 1'b1; // RL12
    else if (flash_err)
      next_cause.flash = 1'b1; // RL18
    else if (wr_cause && SFR_REQ.wdata[`RSC_BIT_SW])
      next_cause.sw = 1'b1; // RL19
    else if (usb_trip)
      next_cause.usb = 1'b1; // RL20
  end

  assign any_trip = |next_cause;

  // sequencer: hold while a level source stands, then stretch
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state     <= rsc_pkg::ST_DELAY;
      delay_cnt <= '0;
      SYS_RESET <= 1'b1;
    end
    else
    begin
      case (state)
        rsc_pkg::ST_RUN:
        begin
          delay_cnt <= '0;
          if (any_trip)
          begin
            state     <= hold_src ? rsc_pkg::ST_HOLD : rsc_pkg::ST_DELAY;
            SYS_RESET <= 1'b1;
          end
        end
        rsc_pkg::ST_HOLD:
        begin
          delay_cnt <= '0;
          if (!hold_src)
            state <= rsc_pkg::ST_DELAY;
        end
        rsc_pkg::ST_DELAY:
        begin
          if (hold_src)
          begin
            state     <= rsc_pkg::ST_HOLD;
            delay_cnt <= '0;
          end
          else if (delay_cnt == DW'(`RSC_RESET_DELAY_CYC - 1))
          begin
            state     <= rsc_pkg::ST_RUN; // RL23
            SYS_RESET <= 1'b0;
          end
          else
            delay_cnt <= delay_cnt + 1'b1;
        end
        default:
        begin
          state     <= rsc_pkg::ST_DELAY;
          delay_cnt <= '0;
          SYS_RESET <= 1'b1;
        end
      endcase
    end
  end

  // captured once on entry, then frozen through the run
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      cause <= 8'h02; // RL21
    else if (state == rsc_pkg::ST_RUN && any_trip)
      cause <= next_cause; // RL25
  end

  // own drive echoes through the sync for two more cycles after release
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      drive_hist <= 2'h3;
    else
      drive_hist <= {drive_hist[0], !RST_PIN_OE_N};
  end

  // blind to outside pulls while driving: our own low would hold us forever
  assign pin_ext = pin_low && RST_PIN_OE_N && (drive_hist == 2'h0); // RL6 RL9

  // pin driven low only for power and supply resets
  always_ff @(posedge CLK_SYS)
  begin
    RST_PIN_OUT <= 1'b0;
    if (RST)
      RST_PIN_OE_N <= 1'b0;
    else if (state == rsc_pkg::ST_RUN && any_trip)
      RST_PIN_OE_N <= !next_cause.por; // RL9
    else if (state == rsc_pkg::ST_DELAY && !hold_src
             && delay_cnt == DW'(`RSC_RESET_DELAY_CYC - 1))
      RST_PIN_OE_N <= 1'b1;
  end

  // monitor state survives every reset except power-on
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      SUPPLY_MON_ON <= 1'b1; // RL3
    else if (wr_supply)
      SUPPLY_MON_ON <= SFR_REQ.wdata[`RSC_BIT_MON_ON]; // RL1
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST || !SUPPLY_MON_ON)
      mon_cnt <= '0;
    else if (mon_cnt != MW'(MON_TURNON))
      mon_cnt <= mon_cnt + 1'b1;
  end

  // monitor selection kept across other resets
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      vdm_sel <= 1'b0;
    else if (wr_cause)
      vdm_sel <= SFR_REQ.wdata[`RSC_BIT_POR]; // RL21
  end

  // other enables drop on every reset so a standing source cannot loop
  always_ff @(posedge CLK_SYS)
  begin
    if (RST || SYS_RESET)
    begin
      usb_en      <= 1'b0;
      cmp_en      <= 1'b0;
      CLK_LOSS_EN <= 1'b0;
    end
    else if (wr_cause)
    begin
      usb_en      <= SFR_REQ.wdata[`RSC_BIT_USB]; // RL20
      cmp_en      <= SFR_REQ.wdata[`RSC_BIT_CMP]; // RL10
      CLK_LOSS_EN <= SFR_REQ.wdata[`RSC_BIT_CLK_LOSS]; // RL8
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      SFR_RDATA <= 8'h00;
    else if (SFR_REQ.rd && SFR_REQ.addr == `RSC_ADDR_SUPPLY)
      SFR_RDATA <= {SUPPLY_MON_ON, level_ok, 6'h00}; // RL4 RL5
    else if (SFR_REQ.rd && SFR_REQ.addr == `RSC_ADDR_CAUSE && SFR_REQ.rmw)
      SFR_RDATA <= {usb_en, cause.flash, cmp_en, 1'b0,
                    cause.wdog, CLK_LOSS_EN, vdm_sel, cause.pin}; // RL22
    else if (SFR_REQ.rd && SFR_REQ.addr == `RSC_ADDR_CAUSE)
      SFR_RDATA <= cause; // RL13 RL18 RL6
    else if (SFR_REQ.rd)
      SFR_RDATA <= 8'h00;
  end
endmodule : rsc_top
`default_nettype wire

// File: sim/rsc_checker_properties.sv
// port assertions of the reset source controller
`timescale 1ns/1ps
`default_nettype none
module rsc_checker (
  // clock and reset
  input wire logic                  CLK_SYS,
  input wire logic                  RST,
  // pin and sources
  input wire logic                  RST_PIN_IN_N,
  input wire logic                  RST_PIN_OE_N,
  input wire logic                  CLK_LOSS_EXPIRED,
  // registers
  input wire rsc_pkg::rsc_sfr_req_t SFR_REQ,
  input wire logic [7:0]            SFR_RDATA,
  // system side
  input wire logic                  SYS_RESET,
  input wire logic                  SUPPLY_MON_ON,
  input wire logic                  CLK_LOSS_EN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic ef_wr;
  logic ff_wr;
  assign ef_wr = SFR_REQ.wr && SFR_REQ.addr == 8'hEF && !SYS_RESET;
  assign ff_wr = SFR_REQ.wr && SFR_REQ.addr == 8'hFF && !SYS_RESET;
  a_sw_reset_force: assert property (
    ef_wr && SFR_REQ.wdata[4] |=> SYS_RESET && RST_PIN_OE_N) else $error("sw reset");
  a_reset_delay_held: assert property (
    $fell(SYS_RESET) |-> RST_PIN_OE_N && $past(SYS_RESET, 50)) else $error("short delay");
  a_power_on_state: assert property (
    $fell(RST) |-> SUPPLY_MON_ON && !CLK_LOSS_EN) else $error("power-on state");
  a_pin_low_reset: assert property (
    $fell(RST_PIN_IN_N) && !SYS_RESET |-> ##[1:4] SYS_RESET) else $error("pin reset");
  a_clk_loss_reset: assert property (
    CLK_LOSS_EN && CLK_LOSS_EXPIRED && !SYS_RESET |-> ##[1:4] SYS_RESET)
    else $error("clock loss");
  a_clk_loss_write: assert property (
    ef_wr && !SFR_REQ.wdata[4] && !SFR_REQ.wdata[1] |=> CLK_LOSS_EN == $past(SFR_REQ.wdata[2]))
    else $error("clock loss enable");
  a_monitor_on_write: assert property (
    ff_wr |=> SUPPLY_MON_ON == $past(SFR_REQ.wdata[7])) else $error("monitor enable");
  a_supply_reg_read: assert property (
    SFR_REQ.rd && SFR_REQ.addr == 8'hFF && !SYS_RESET
    |=> SFR_RDATA[7] == SUPPLY_MON_ON && SFR_RDATA[5:0] == 6'h00) else $error("supply read");
endmodule : rsc_checker
`default_nettype wire

// File: sim/rsc_pin_driver.sv
// external circuitry on the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_driver (
  // clock and request
  input  wire logic clk,
  input  wire logic press,
  // wire
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  output logic      pin_n
);
  int left = 0;
  // a short press is stretched so the reset is certain
  always @(posedge clk)
    if (press && left == 0)
      left <= 160;
    else if (left > 0)
      left <= left - 1;
  // pull-up holds the line high unless someone pulls low
  assign pin_n = (left == 0) && (dev_oe_n || dev_out);
endmodule : rsc_pin_driver
`default_nettype wire

// File: sim/tb_rsc_top.sv
// self-checking bench of the reset source controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("mismatch at %0t: %h not %h", $time, g, e); end end
module tb_rsc_top;
  logic clk = 1'b0, rst = 1'b1, press = 1'b0, supply = 1'b1, cmp = 1'b0, loss = 1'b0;
  logic vbus = 1'b0, usb_on = 1'b0, usb_rst = 1'b0, vpol = 1'b1, kick = 1'b1, f64 = 1'b0;
  logic pin_n, pin_out, pin_oe_n, sys_reset, mon_on, loss_en;
  logic wdis = 1'b0;
  logic [7:0] rdata;
  rsc_pkg::rsc_flash_req_t fr = '0;
  rsc_pkg::rsc_sfr_req_t   sq = '0;
  int fails = 0, compares = 0, seed = 16118;
  int exp_q[$];
  int kinds[13] = '{0, 2, 5, 3, 6, 6, 6, 6, 6, 4, 7, 7, 1};
  logic [4:0] fmode[5] = '{5'h12, 5'h08, 5'h04, 5'h09, 5'h12};
  always #50 clk = ~clk;
  rsc_top #(.WDOG_TICKS(4), .MON_TURNON(8)) dut_u (
    .CLK_SYS(clk), .RST(rst), .RST_PIN_IN_N(pin_n), .RST_PIN_OUT(pin_out),
    .RST_PIN_OE_N(pin_oe_n), .SUPPLY_ABOVE(supply), .CMP_BELOW(cmp),
    .CLK_LOSS_EXPIRED(loss), .VBUS_LEVEL(vbus), .USB_ON(usb_on), .USB_BUS_RESET(usb_rst),
    .VBUS_POLARITY(vpol), .WDOG_KICK(kick), .WDOG_DISABLE(wdis), .FLASH_REQ(fr),
    .FLASH_64K(f64), .SFR_REQ(sq), .SFR_RDATA(rdata), .SYS_RESET(sys_reset),
    .SUPPLY_MON_ON(mon_on), .CLK_LOSS_EN(loss_en));
  rsc_pin_driver pin_u (.clk(clk), .press(press), .dev_out(pin_out), .dev_oe_n(pin_oe_n),
    .pin_n(pin_n));
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d, input logic m);
    @(posedge clk);
    #10 sq = {w, !w, m, a, d};
    @(posedge clk);
    #10 sq = '0;
  endtask : sfr
  task automatic flash(input logic [4:0] f, input logic [15:0] a);
    @(posedge clk);
    #10 fr = {f, a};
    @(posedge clk);
    #10 fr = '0;
  endtask : flash
  task automatic wait_sys(input logic lvl);
    for (int n = 0; n < 400 && sys_reset !== lvl; n++)
      #100;
    `CHK(sys_reset, lvl)
  endtask : wait_sys
  // releases every source, then reads back the recorded cause
  task automatic expect_reset(input logic oe);
    wait_sys(1'b1);
    `CHK(pin_oe_n, oe)
    {press, loss, cmp, usb_on, usb_rst, vbus} = '0;
    {supply, kick} = 2'b11;
    wait_sys(1'b0);
    sfr(1'b1, 8'hFF, 8'h80, 1'b0);
    sfr(1'b0, 8'hEF, 8'h00, 1'b0);
    `CHK(rdata, 8'(exp_q.pop_front()))
  endtask : expect_reset
  task automatic provoke(input int k, input int i);
    logic [15:0] lim;
    logic [15:0] a;
    f64 = 1'($random(seed));
    lim = f64 ? 16'hFBFF : 16'h7FFF;
    a = 16'(lim + 1 + {$random(seed)} % (16'hFFFF - lim));
    exp_q.push_back(1 << k);
    case (k)
      0: press = 1'b1;
      1:
      begin
        sfr(1'b1, 8'hEF, 8'h02, 1'b0);
        supply = 1'b0;
      end
      2:
      begin
        sfr(1'b1, 8'hEF, 8'h04, 1'b0);
        loss = 1'b1;
      end
      3: kick = 1'b0;
      4: sfr(1'b1, 8'hEF, 8'h10, 1'b0);
      5:
      begin
        sfr(1'b1, 8'hEF, 8'h20, 1'b0);
        cmp = 1'b1;
      end
      6:
      begin
        if (i < 7)
        begin
          flash(fmode[i - 4], lim);
          #400;
          `CHK(sys_reset, 1'b0)
        end
        if (i == 8)
          sfr(1'b1, 8'hFF, 8'h00, 1'b0);
        flash(fmode[i - 4], i > 6 ? 16'h0100 : a);
      end
      default:
      begin
        sfr(1'b1, 8'hEF, 8'h80, 1'b0);
        usb_on = (i == 10);
        usb_rst = (i == 10);
        vbus = (i == 10) ? 1'b0 : vpol;
      end
    endcase
  endtask : provoke
  initial
  begin
    repeat (5) @(posedge clk);
    #10 rst = 1'b0;
    wait_sys(1'b0);
    sfr(1'b0, 8'hEF, 8'h00, 1'b0);
    `CHK(rdata, 8'h02)
    sfr(1'b0, 8'hFF, 8'h00, 1'b0);
    `CHK(rdata, 8'hC0)
    sfr(1'b1, 8'hFF, 8'h3F, 1'b0);
    supply = 1'b0;
    #300;
    sfr(1'b0, 8'hFF, 8'h00, 1'b0);
    `CHK(rdata, 8'h00)
    `CHK(sys_reset, 1'b0)
    supply = 1'b1;
    sfr(1'b1, 8'hFF, 8'h80, 1'b0);
    #1000;
    sfr(1'b1, 8'hEF, 8'h04, 1'b0);
    sfr(1'b0, 8'hEF, 8'h00, 1'b1);
    `CHK(rdata, 8'h04)
    sfr(1'b0, 8'hEF, 8'h00, 1'b0);
    `CHK(rdata, 8'h02)
    sfr(1'b1, 8'hEF, 8'h00, 1'b0);
    loss = 1'b1;
    #500;
    `CHK(sys_reset, 1'b0)
    loss = 1'b0;
    kick = 1'b0;
    wdis = 1'b1;
    @(posedge clk);
    #10 wdis = 1'b0;
    #8000;
    `CHK(sys_reset, 1'b0)
    kick = 1'b1;
    sfr(1'b1, 8'hFF, 8'h00, 1'b0);
    sfr(1'b1, 8'hFF, 8'h80, 1'b0);
    sfr(1'b1, 8'hEF, 8'h02, 1'b0);
    exp_q.push_back(2);
    expect_reset(1'b0);
    foreach (kinds[i])
    begin
      provoke(kinds[i], i);
      expect_reset(kinds[i] != 1);
    end
    conclude();
  end
  // cut a hang short
  initial
  begin
    #2000000;
    fails++;
    conclude();
  end
endmodule : tb_rsc_top
bind rsc_top rsc_checker chk_u (.CLK_SYS, .RST, .RST_PIN_IN_N, .RST_PIN_OE_N,
  .CLK_LOSS_EXPIRED, .SFR_REQ, .SFR_RDATA, .SYS_RESET, .SUPPLY_MON_ON, .CLK_LOSS_EN);
`default_nettype wire
